// file: dv/conv_sequencer_checker.sv
// port-level checker for the converter sequencer, bound into every instance
// assumes one clock domain and the register map and timing of conv_pkg
`timescale 1ns/100ps
module conv_sequencer_checker #(
    parameter int DIV_W = conv_pkg::DIVIDER_W
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire conv_pkg::reg_req_t         reg_req,
    input  wire logic [15:0]                reg_rdata,
    input  wire logic                       reg_rvalid,
    input  wire logic [conv_pkg::RAW_W-1:0] sar_raw,
    input  wire conv_pkg::analog_ctrl_t     analog_ctrl,
    input  wire logic                       converter_clock,
    input  wire logic                       seq_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // window lengths counted in converter ticks, so any divider setting is judged alike
    logic       prev_cc;
    logic       after_conv;
    logic [7:0] samp_cnt;
    logic [7:0] conv_cnt;
    logic [7:0] gap_cnt;
    wire        tog      = converter_clock ^ prev_cc;
    wire        sel_wr   = reg_req.wr && reg_req.addr == conv_pkg::OFS_CHAN_SELECT;
    wire        sel_none = (reg_req.wdata & conv_pkg::CHAN_IMPL_MASK) == 16'h0000;
    wire        sense_wr = reg_req.wr && reg_req.addr == conv_pkg::OFS_SENSE_CTRL;
    wire        res_rd   = reg_req.rd && reg_req.addr >= conv_pkg::OFS_RESULT_BASE
                           && reg_req.addr <= conv_pkg::OFS_RESULT_LAST;
    wire        idle_win = !analog_ctrl.sample && !analog_ctrl.convert;

    // helper counters; cleared while their window is shut
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_cc    <= 1'b0;
            after_conv <= 1'b0;
            samp_cnt   <= 8'h00;
            conv_cnt   <= 8'h00;
            gap_cnt    <= 8'h00;
        end else begin
            prev_cc    <= converter_clock;
            after_conv <= seq_busy && !sel_wr && (after_conv || analog_ctrl.convert);
            samp_cnt   <= analog_ctrl.sample ? samp_cnt + 8'(tog) : 8'h00;
            conv_cnt   <= analog_ctrl.convert ? conv_cnt + 8'(tog) : 8'h00;
            gap_cnt    <= idle_win ? gap_cnt + 8'(tog) : 8'h00;
        end
    end

    rvalid_delay_a: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read answer missing one cycle after request");
    result_pad_a: assert property (res_rd |=> reg_rdata[5:0] == 6'h00)
        else $error("result low bits not zero");
    sense_reserved_a: assert property (reg_req.rd && reg_req.addr == conv_pkg::OFS_SENSE_CTRL
        |=> reg_rdata[6:4] == 3'h0 && reg_rdata[15:8] == 8'h00) else $error("sense control reserved bits set");
    zero_stop_a: assert property (sel_wr && sel_none |-> ##[1:2] !seq_busy)
        else $error("zero channel select did not stop the scan");
    scan_start_a: assert property (sel_wr && !sel_none
        |-> ##[1:2] (seq_busy && analog_ctrl.mux_channel == 4'hf)) else $error("scan did not start at channel 15");
    sample_len_a: assert property ($fell(analog_ctrl.sample) && seq_busy && !$past(sel_wr) |-> samp_cnt == 8'h09)
        else $error("sampling window not 9 ticks");
    convert_len_a: assert property ($fell(analog_ctrl.convert) && !$past(sel_wr) |-> conv_cnt == 8'h12)
        else $error("conversion window not 18 ticks");
    sample_to_convert_a: assert property ($fell(analog_ctrl.sample) && seq_busy && !$past(sel_wr)
        |-> analog_ctrl.convert) else $error("conversion did not follow sampling");
    gap_len_a: assert property ($rose(analog_ctrl.sample) && after_conv |-> gap_cnt == 8'h04)
        else $error("gap between channels not 4 ticks");
    comp_window_a: assert property (analog_ctrl.charge_comp |-> analog_ctrl.sample)
        else $error("charge compensation outside sampling");
    amp_hold_a: assert property (!$stable({analog_ctrl.amp_enable, analog_ctrl.amp_gain})
        |-> $past(sense_wr) || $past(sense_wr, 2)) else $error("amplifier setting changed without a write");

    // main scenarios reached
    cover property ($fell(analog_ctrl.convert));
    cover property ($rose(analog_ctrl.sample) && after_conv);
    cover property (analog_ctrl.charge_comp);
endmodule

bind conv_sequencer conv_sequencer_checker #(.DIV_W(DIV_W)) checker_u (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sar_raw(sar_raw), .analog_ctrl(analog_ctrl),
    .converter_clock(converter_clock), .seq_busy(seq_busy));

// file: dv/tb_conv_sequencer.sv
// self-checking bench for the converter sequencer and current-sense control
// assumes the checker binds itself; the divider stays at zero except in its own test
`timescale 1ns/100ps
module tb_conv_sequencer;
    logic                       clk;
    logic                       rst_b;
    conv_pkg::reg_req_t         reg_req;
    logic [15:0]                reg_rdata;
    logic                       reg_rvalid;
    logic [conv_pkg::RAW_W-1:0] sar_raw;
    logic [conv_pkg::RAW_W-1:0] sar_late;
    conv_pkg::analog_ctrl_t     analog_ctrl;
    logic                       converter_clock;
    logic                       seq_busy;
    logic [3:0]                 samp_mux;
    logic [15:0]                rd;
    int                         mismatches;
    int                         samples_checked;
    int                         cycles;
    int                         busy_n;
    int                         samp_n;
    int                         conv_n;
    int                         comp_n;
    logic [3:0]                 chans [6] = '{4'h0, 4'h8, 4'h9, 4'hb, 4'he, 4'hf};

    conv_sequencer #(.DIV_W(conv_pkg::DIVIDER_W)) dut_u (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sar_raw(sar_raw), .analog_ctrl(analog_ctrl),
        .converter_clock(converter_clock), .seq_busy(seq_busy));

    // clock, and a hang guard far above the several hundred cycles the tests need
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // register port: one-cycle strobes, read answer one cycle after the taking edge
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        reg_req <= '0;
        @(posedge clk);
        d = reg_rvalid ? reg_rdata : 16'hxxxx;
    endtask

    // start a scan and watch it end; sar_raw moves to sar_late once the first conversion is over
    task automatic run_scan(input logic [15:0] sel);
        logic prev_conv;
        prev_conv = 1'b0;
        busy_n = 0;
        samp_n = 0;
        conv_n = 0;
        comp_n = 0;
        wr_reg(conv_pkg::OFS_CHAN_SELECT, sel);
        while (!(busy_n > 0 && !seq_busy)) begin
            @(posedge clk);
            busy_n += int'(seq_busy);
            samp_n += int'(analog_ctrl.sample);
            conv_n += int'(analog_ctrl.convert);
            comp_n += int'(analog_ctrl.charge_comp);
            if (analog_ctrl.sample) samp_mux = analog_ctrl.mux_channel;
            if (prev_conv && !analog_ctrl.convert) sar_raw <= sar_late;
            prev_conv = analog_ctrl.convert;
        end
    endtask

    task automatic test_sense;
        rd_reg(conv_pkg::OFS_SENSE_CTRL, rd);
        chk("sense reset", 16'h0000, rd);
        rd_reg(8'hfe, rd);
        chk("unmapped", 16'h0000, rd);
        wr_reg(conv_pkg::OFS_SENSE_CTRL, 16'h00ff);
        rd_reg(conv_pkg::OFS_SENSE_CTRL, rd);
        chk("sense readback", 16'h008f, rd);
        chk("amp on", 16'h0001, 16'(analog_ctrl.amp_enable));
        for (int g = 0; g < 8; g++) begin
            wr_reg(conv_pkg::OFS_SENSE_CTRL, 16'h0088 | 16'(g));
            repeat (2) @(posedge clk);
            chk("gain", 16'(g), 16'(analog_ctrl.amp_gain));
        end
        // compensation disabled while the shunt channel converts
        run_scan(16'h0200);
        chk("shunt mux", 16'h0009, 16'(samp_mux));
        chk("comp off", 16'h0000, 16'(comp_n));
        wr_reg(conv_pkg::OFS_SENSE_CTRL, 16'h0000);
        repeat (2) @(posedge clk);
        chk("amp off", 16'h0000, 16'(analog_ctrl.amp_enable));
        $display("test sense control done");
    endtask

    task automatic test_single(input logic [3:0] ch, input logic [9:0] raw);
        int pos;
        pos = (ch == 4'hf) ? 0 : int'(ch) + 1;
        sar_raw <= raw;
        sar_late <= raw;
        run_scan(16'h0001 << ch);
        chk("mux", 16'(ch), 16'(samp_mux));
        chk("busy", 16'h0001, 16'(busy_n >= pos + 27 && busy_n <= pos + 30));
        chk("sample", 16'h0009, 16'(samp_n));
        chk("convert", 16'h0012, 16'(conv_n));
        chk("charge comp", 16'h0009, 16'(comp_n));
        rd_reg(conv_pkg::OFS_CHAN_DONE, rd);
        chk("done", 16'h0001 << ch, rd);
        rd_reg(conv_pkg::OFS_RESULT_BASE + 8'({ch, 1'b0}), rd);
        chk("result", {raw, 6'h00}, rd);
        rd_reg(conv_pkg::OFS_CHAN_DONE, rd);
        chk("done cleared", 16'h0000, rd);
        $display("test single channel %0d done", ch);
    endtask

    // reference 20 then input 300: compensated 300 - (20 - 8) = 288
    task automatic test_offset(input logic offset_comp_enable);
        wr_reg(conv_pkg::OFS_CONV_CONFIG, {offset_comp_enable, 15'h0000});
        sar_raw <= 10'h014;
        sar_late <= 10'h12c;
        run_scan(16'h8400);
        chk("seq busy", 16'h0001, 16'(busy_n >= 58 && busy_n <= 61));
        chk("seq sample", 16'h0012, 16'(samp_n));
        rd_reg(conv_pkg::OFS_RESULT_BASE + 8'h1e, rd);
        chk("ref result", 16'h0500, rd);
        rd_reg(conv_pkg::OFS_RESULT_BASE + 8'h14, rd);
        chk("comp result", {offset_comp_enable ? 10'h120 : 10'h12c, 6'h00}, rd);
        $display("test offset compensation %0d done", offset_comp_enable);
    endtask

    task automatic test_abort_divider;
        wr_reg(conv_pkg::OFS_CONV_CONFIG, 16'h0003);
        run_scan(16'h8000);
        chk("divided sample", 16'h0024, 16'(samp_n));
        wr_reg(conv_pkg::OFS_CONV_CONFIG, 16'h0000);
        wr_reg(conv_pkg::OFS_CHAN_SELECT, 16'h4000);
        rd_reg(conv_pkg::OFS_CHAN_DONE, rd);
        chk("done after rewrite", 16'h0000, rd);
        wr_reg(conv_pkg::OFS_CHAN_SELECT, 16'h0000);
        repeat (2) @(posedge clk);
        chk("stopped", 16'h0000, 16'(seq_busy));
        $display("test divider and abort done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        reg_req = '0;
        sar_raw = '0;
        sar_late = '0;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        test_sense();
        foreach (chans[i]) test_single(chans[i], 10'(i * 37 + 5));
        test_offset(1'b1);
        test_offset(1'b0);
        // enable alone without the reference selected leaves results raw
        wr_reg(conv_pkg::OFS_CONV_CONFIG, 16'h8000);
        test_single(4'ha, 10'h2a5);
        test_abort_divider();
        stop_test();
    end
endmodule

// file: rtl/conv_clock_divider.sv
// programmable prescaler making the converter clock from the die link clock
// assumes the divide value is static while a sequence runs
`timescale 1ns/100ps
module conv_clock_divider #(
    parameter int DIV_W = 6
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [DIV_W-1:0] divide,
    output logic                  tick,
    output logic                  converter_clock
);
    logic [DIV_W-1:0] count;
    wire              wrap = (count >= divide);

    if (DIV_W < 1) begin : g_check
        $error("conv_clock_divider: DIV_W must be at least 1");
    end

    // one tick every divide+1 link clocks; the pin clock toggles on each tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count           <= '0;
            tick            <= 1'b0;
            converter_clock <= 1'b0;
        end else begin
            count           <= wrap ? '0 : count + 1'b1;
            tick            <= wrap;
            converter_clock <= wrap ? ~converter_clock : converter_clock;
        end
    end
endmodule

// file: rtl/conv_pkg.sv
// shared constants and carrier types for the converter sequencer and current-sense control
// assumes a 16-bit register port on the die-to-die link side and one 100 MHz clock
package conv_pkg;

    // register offsets on the die-to-die register port
    localparam logic [7:0] OFS_SENSE_CTRL    = 8'h3c;
    localparam logic [7:0] OFS_CONV_CONFIG   = 8'h80;
    localparam logic [7:0] OFS_CHAN_SELECT   = 8'h82;
    localparam logic [7:0] OFS_CHAN_DONE     = 8'h84;
    localparam logic [7:0] OFS_RESULT_BASE   = 8'h86;
    localparam logic [7:0] OFS_RESULT_LAST   = 8'ha4;

    // current-sense control fields
    localparam int         SENSE_EN_BIT      = 7;
    localparam int         CHARGE_DIS_BIT    = 3;
    localparam int         GAIN_LSB          = 0;
    localparam int         GAIN_W            = 3;
    localparam logic [7:0] SENSE_CTRL_MASK   = 8'h8f;
    localparam logic [7:0] SENSE_CTRL_RESET  = 8'h00;

    // converter config fields
    localparam int         OFFSET_EN_BIT     = 15;
    localparam int         DIVIDER_LSB       = 0;
    localparam int         DIVIDER_W         = 6;
    localparam logic [15:0] CONV_CONFIG_MASK = 16'h803f;
    localparam logic [15:0] CONV_CONFIG_RESET = 16'h0000;

    // channel map; channel 13 has no input behind it
    localparam logic [15:0] CHAN_IMPL_MASK   = 16'hdfff;
    localparam logic [3:0] CH_LAST_EXTERNAL  = 4'h8;
    localparam logic [3:0] CH_SHUNT_CURRENT  = 4'h9;
    localparam logic [3:0] CH_BATTERY_LEVEL  = 4'ha;
    localparam logic [3:0] CH_DIE_TEMP       = 4'hb;
    localparam logic [3:0] CH_INTERNAL_SUPPLY = 4'hc;
    localparam logic [3:0] CH_SLEEP_BANDGAP  = 4'he;
    localparam logic [3:0] CH_CAL_REFERENCE  = 4'hf;

    // conversion timing in converter-clock cycles
    localparam logic [4:0] SAMPLE_CYCLES     = 5'h09;
    localparam logic [4:0] CONVERT_CYCLES    = 5'h12;
    localparam logic [4:0] GAP_CYCLES        = 5'h04;

    // offset compensation
    localparam int         RAW_W             = 10;
    localparam logic [9:0] CAL_IDEAL_CODE    = 10'h008;
    localparam int         RESULT_PAD        = 6;

    typedef enum logic [2:0] {
        SEQ_IDLE    = 3'b000,
        SEQ_COUNT   = 3'b001,
        SEQ_SAMPLE  = 3'b010,
        SEQ_CONVERT = 3'b011,
        SEQ_GAP     = 3'b100
    } seq_state_t;

    // one register access from the die-to-die link
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    // controls toward the analog front end
    typedef struct packed {
        logic [3:0]  mux_channel;
        logic        sample;
        logic        convert;
        logic        charge_comp;
        logic        amp_enable;
        logic [2:0]  amp_gain;
    } analog_ctrl_t;

endpackage

// file: rtl/conv_sequencer.sv
// converter sequencer, offset compensation and current-sense control registers
// assumes register accesses arrive one per cycle on the link clock and the SAR raw code is held steady
// What this block does
// - channels 0 to 8 route the three port pins then six high-voltage inputs
// - channel 9 carries the amplified shunt current signal
// - channel 11 carries the die temperature sensor
// - channel 14 samples the sleep bandgap for a chain health check
// - channel 15 connects the calibration reference used for offset removal
// - offset compensation treats a code of 8 as the ideal reference result
// - compensation only when enable bit set and channel 15 selected at start
// - compensation works only in sequences that include channel 15, never for a single conversion
// - converter clock comes from a programmable divider of the link clock
// - each channel samples for 9 converter-clock cycles
// - each channel then converts for a further 18 cycles
// - counter steps 15, 0, 1 .. 14 one cycle each to the first channel
// - 4 cycles between one conversion's end and next sampling start
// - counting to the next channel overlaps the current conversion
// - control bit 7 enables the current-sense amplifier
// - control bit 3 set disables input-filter charge compensation
// - charge compensation runs in step with each sampling window when enabled
// - bits 2 to 0 select one of eight amplifier gains
// - channel-select write stops, clears done flags, restarts; zero stops
// - reading a result clears its done flag; results left-adjusted
`timescale 1ns/100ps
module conv_sequencer #(
    parameter int DIV_W = conv_pkg::DIVIDER_W
) (
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire conv_pkg::reg_req_t          reg_req,
    output logic [15:0]                      reg_rdata,
    output logic                             reg_rvalid,
    input  wire logic [conv_pkg::RAW_W-1:0]  sar_raw,
    output conv_pkg::analog_ctrl_t           analog_ctrl,
    output logic                             converter_clock,
    output logic                             seq_busy
);
    // register state
    logic [7:0]                 sense_ctrl;
    logic [15:0]                conv_config;
    logic [15:0]                chan_select;
    logic [15:0]                chan_done;
    logic [conv_pkg::RAW_W-1:0] result [16];

    // sequencer state
    conv_pkg::seq_state_t       state;
    conv_pkg::seq_state_t       next_state;
    logic [3:0]                 chan;
    logic [4:0]                 phase;
    logic                       comp_armed;
    logic                       cal_valid;
    logic [conv_pkg::RAW_W-1:0] cal_raw;
    logic [conv_pkg::RAW_W-1:0] raw_meta;
    logic [conv_pkg::RAW_W-1:0] raw_sync;
    logic                       tick;

    if (DIV_W < 1 || DIV_W > conv_pkg::DIVIDER_W) begin : g_check
        $error("conv_sequencer: DIV_W out of the config field range");
    end

    // address decode
    wire        hit_sense  = (reg_req.addr == conv_pkg::OFS_SENSE_CTRL);
    wire        hit_config = (reg_req.addr == conv_pkg::OFS_CONV_CONFIG);
    wire        hit_select = (reg_req.addr == conv_pkg::OFS_CHAN_SELECT);
    wire        hit_done   = (reg_req.addr == conv_pkg::OFS_CHAN_DONE);
    wire        hit_result = (reg_req.addr >= conv_pkg::OFS_RESULT_BASE) &&
                             (reg_req.addr <= conv_pkg::OFS_RESULT_LAST) && !reg_req.addr[0];
    wire [7:0]  result_ofs = reg_req.addr - conv_pkg::OFS_RESULT_BASE;
    wire [3:0]  result_idx = result_ofs[4:1];
    wire        select_wr  = reg_req.wr && hit_select;
    wire        result_rd  = reg_req.rd && hit_result;

    // config fields
    wire             offset_en   = conv_config[conv_pkg::OFFSET_EN_BIT];
    wire [DIV_W-1:0] divide      = conv_config[conv_pkg::DIVIDER_LSB +: DIV_W];
    wire             amp_on      = sense_ctrl[conv_pkg::SENSE_EN_BIT];
    wire             charge_dis  = sense_ctrl[conv_pkg::CHARGE_DIS_BIT];
    wire [2:0]       gain        = sense_ctrl[conv_pkg::GAIN_LSB +: conv_pkg::GAIN_W];
    wire [15:0]      select_new  = reg_req.wdata & conv_pkg::CHAN_IMPL_MASK;

    // scan order 15, 0, 1 .. 14: position of a channel is channel+1 modulo 16
    function automatic logic [4:0] find_after(input logic [15:0] sel, input logic [3:0] cur);
        logic [4:0] found;
        logic [3:0] cand;
        found = 5'h10;
        for (int step = 15; step >= 1; step--) begin
            cand = 4'(int'(cur) + step);
            if (sel[cand] && (4'(cand + 4'h1) > 4'(cur + 4'h1))) begin
                found = {1'b0, cand};
            end
        end
        return found;
    endfunction

    wire [4:0] next_find  = find_after(chan_select, chan);
    wire       more_chan  = !next_find[4];
    wire       phase_end  = tick && (phase == 5'h01);
    wire       count_hit  = chan_select[chan];
    wire       conv_done  = (state == conv_pkg::SEQ_CONVERT) && phase_end;

    // offset compensation: subtract measured reference minus ideal, clamp to the code range
    wire        apply_comp = comp_armed && cal_valid && (chan != conv_pkg::CH_CAL_REFERENCE);
    wire [11:0] offset_amt = {2'b00, cal_raw} - {2'b00, conv_pkg::CAL_IDEAL_CODE};
    wire [11:0] comp_sum   = {2'b00, raw_sync} - offset_amt;
    wire [9:0]  comp_code  = comp_sum[11] ? 10'h000 : (comp_sum[10] ? 10'h3ff : comp_sum[9:0]);
    wire [9:0]  store_code = apply_comp ? comp_code : raw_sync;

    // sequencer next state on converter-clock ticks
    always_comb begin
        next_state = state;
        unique case (state)
            conv_pkg::SEQ_IDLE:    next_state = state;
            conv_pkg::SEQ_COUNT:   if (tick && count_hit) begin
                next_state = conv_pkg::SEQ_SAMPLE;
            end
            conv_pkg::SEQ_SAMPLE:  if (phase_end) begin
                next_state = conv_pkg::SEQ_CONVERT;
            end
            conv_pkg::SEQ_CONVERT: if (phase_end) begin
                next_state = more_chan ? conv_pkg::SEQ_GAP : conv_pkg::SEQ_IDLE;
            end
            conv_pkg::SEQ_GAP:     if (phase_end) begin
                next_state = conv_pkg::SEQ_SAMPLE;
            end
            default:               next_state = conv_pkg::SEQ_IDLE;
        endcase
    end

    // raw SAR code arrives from the analog die, so it is resynchronised first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            raw_meta <= '0;
            raw_sync <= '0;
        end else begin
            raw_meta <= sar_raw;
            raw_sync <= raw_meta;
        end
    end

    // converter clock prescaler
    conv_clock_divider #(
        .DIV_W           (DIV_W)
    ) u_divider (
        .clk             (clk),
        .rst_b           (rst_b),
        .divide          (divide),
        .tick            (tick),
        .converter_clock (converter_clock)
    );

    // sequencer state, channel counter and phase counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= conv_pkg::SEQ_IDLE;
            chan  <= conv_pkg::CH_CAL_REFERENCE;
            phase <= '0;
        end else if (select_wr) begin
            // a write aborts at once; an empty selection leaves the sequencer idle
            state <= (select_new == 16'h0000) ? conv_pkg::SEQ_IDLE : conv_pkg::SEQ_COUNT;
            chan  <= conv_pkg::CH_CAL_REFERENCE;
            phase <= '0;
        end else begin
            state <= next_state;
            if (state == conv_pkg::SEQ_COUNT && tick && !count_hit) begin
                chan <= chan + 4'h1;
            end
            if (state == conv_pkg::SEQ_GAP && phase_end) begin
                chan <= next_find[3:0];
            end
            if (tick) begin
                unique case (next_state)
                    conv_pkg::SEQ_SAMPLE:  phase <= (state != conv_pkg::SEQ_SAMPLE) ?
                                                    conv_pkg::SAMPLE_CYCLES : phase - 5'h01;
                    conv_pkg::SEQ_CONVERT: phase <= (state != conv_pkg::SEQ_CONVERT) ?
                                                    conv_pkg::CONVERT_CYCLES : phase - 5'h01;
                    conv_pkg::SEQ_GAP:     phase <= (state != conv_pkg::SEQ_GAP) ?
                                                    conv_pkg::GAP_CYCLES : phase - 5'h01;
                    default:               phase <= '0;
                endcase
            end
        end
    end

    // compensation arming and reference capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            comp_armed <= 1'b0;
            cal_valid  <= 1'b0;
            cal_raw    <= '0;
        end else if (select_wr) begin
            comp_armed <= offset_en && select_new[conv_pkg::CH_CAL_REFERENCE];
            cal_valid  <= 1'b0;
        end else if (conv_done && chan == conv_pkg::CH_CAL_REFERENCE) begin
            cal_valid  <= 1'b1;
            cal_raw    <= raw_sync;
        end
    end

    // software registers; unused bits are masked so they hold zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sense_ctrl  <= conv_pkg::SENSE_CTRL_RESET;
            conv_config <= conv_pkg::CONV_CONFIG_RESET;
            chan_select <= '0;
        end else begin
            if (reg_req.wr && hit_sense) begin
                sense_ctrl <= reg_req.wdata[7:0] & conv_pkg::SENSE_CTRL_MASK;
            end
            if (reg_req.wr && hit_config) begin
                conv_config <= reg_req.wdata & conv_pkg::CONV_CONFIG_MASK;
            end
            if (select_wr) begin
                chan_select <= select_new;
            end
        end
    end

    // done flags: a completing conversion wins over a read-clear of the same flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chan_done <= '0;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (select_wr) begin
                    chan_done[i] <= 1'b0;
                end else if (conv_done && chan == 4'(i)) begin
                    chan_done[i] <= 1'b1;
                end else if (result_rd && result_idx == 4'(i)) begin
                    chan_done[i] <= 1'b0;
                end
            end
        end
    end

    // result storage, one slot per channel
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 16; i++) begin
                result[i] <= '0;
            end
        end else if (conv_done) begin
            result[chan] <= store_code;
        end
    end

    // read data mux; results sit left-adjusted with zero low bits
    wire [15:0] rd_mux = hit_sense  ? {8'h00, sense_ctrl} :
                         hit_config ? conv_config :
                         hit_select ? chan_select :
                         hit_done   ? chan_done :
                         hit_result ? {result[result_idx], {conv_pkg::RESULT_PAD{1'b0}}} :
                         16'h0000;

    // registered read answer, one cycle after the request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= reg_req.rd ? rd_mux : 16'h0000;
            reg_rvalid <= reg_req.rd;
        end
    end

    // analog front-end controls, registered so the mux never sees decode glitches
    wire in_sample  = (next_state == conv_pkg::SEQ_SAMPLE);
    wire in_convert = (next_state == conv_pkg::SEQ_CONVERT);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            analog_ctrl <= '0;
            seq_busy    <= 1'b0;
        end else begin
            // channel number drives the mux directly: 0..8 external, 9 shunt, 11 temp, 14 bandgap, 15 ref
            analog_ctrl.mux_channel <= select_wr ? conv_pkg::CH_CAL_REFERENCE :
                                       (state == conv_pkg::SEQ_GAP && phase_end) ? next_find[3:0] :
                                       chan;
            analog_ctrl.sample      <= !select_wr && in_sample;
            analog_ctrl.convert     <= !select_wr && in_convert;
            // charge compensation follows the sampling window only
            analog_ctrl.charge_comp <= !select_wr && in_sample && !charge_dis;
            analog_ctrl.amp_enable  <= amp_on;
            analog_ctrl.amp_gain    <= gain;
            seq_busy                <= select_wr ? (select_new != 16'h0000) :
                                       (next_state != conv_pkg::SEQ_IDLE);
        end
    end
endmodule
